// File: rtl/bmf_fifo.sv
`timescale 1ns/1ps
`include "bmf_params.svh"
// What this block does
// - After the first fall-through word, each further word needs a read enable.
// - Fall-through: first word into empty buffer appears after three edges.
// - Fall-through pin level at master reset picks standard or fall-through.
// - Empty/full in standard; fall-through turns only empty into output ready; full and others always.
// - Master reset picks one of eight default offset pairs from three pins.
// - Serial enable plus load shifts one serial bit into the offsets.
// - Write enable plus load loads an offset from the data inputs.
// - Read enable plus load presents an offset on the data outputs.
// - Master reset clears both pointers and captures all strap levels.
// - Partial reset clears pointers, keeps modes and offsets, refreshes flags.
// - Asynchronous timing: almost-empty set on read, cleared on write edge.
// - Asynchronous timing: almost-full set on write, cleared on read edge.
// - Synchronous timing: almost flags follow the count one edge later, on either side.
// - Flag timing pin captured at master reset picks sync or async.
// - Retransmit request low at an edge sends read pointer to start.
// - Latency pin at master reset: low zero latency, high normal.
// - Narrow reads: big-endian gives high part first, little the low part.
// - Byte order pin at master reset: low big-endian, high little-endian.
// - Interspersed parity: bits 8, 17, 26, 35 dropped from offset value.
// - Non-interspersed: bits 8,17,26 valid, 32-35 ignored; data untouched.
// - Width pins select 36/36, 36/18, 36/9, 18/36 or 9/36 ports.
// - Idle indication whenever nothing happens, dropped when a control acts.
module bmf_fifo #(
	parameter int AW = `BMF_ADDR_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic master_reset_n_i,
	input wire logic partial_reset_n_i,
	input wire logic write_enable_n_i,
	input wire logic [`BMF_DATA_W-1:0] write_data_in_i,
	input wire logic read_enable_n_i,
	output logic [`BMF_DATA_W-1:0] read_data_out_o,
	input wire logic offset_load_n_i,
	input wire logic serial_load_enable_n_i,
	input wire logic fall_through_serial_in_i,
	input wire logic offset_select_0_i,
	input wire logic offset_select_1_i,
	input wire logic flag_timing_select_i,
	input wire logic retransmit_request_n_i,
	input wire logic retransmit_latency_select_i,
	input wire logic byte_order_select_i,
	input wire logic parity_layout_select_i,
	input wire logic width_match_enable_i,
	input wire logic input_width_select_i,
	input wire logic output_width_select_i,
	output logic empty_flag_n_o,
	output logic full_flag_n_o,
	output logic half_full_flag_n_o,
	output logic almost_empty_flag_n_o,
	output logic almost_full_flag_n_o,
	output logic power_down_o,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import bmf_pkg::*;
	localparam int OW = AW + 1;
	localparam int DW = `BMF_DATA_W;
	localparam logic [OW-1:0] FULL_CNT = {1'b1, {AW{1'b0}}};
	localparam logic [OW-1:0] HALF_CNT = {2'b01, {(AW-1){1'b0}}};

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [1:0] last_part(input bmf_width_e w);
		case (w)
			BMF_W18: last_part = `BMF_LAST18;
			BMF_W9: last_part = `BMF_LAST9;
			default: last_part = `BMF_LAST36;
		endcase
	endfunction

	// Lane of a part: big-endian walks from the top
	function automatic logic [1:0] lane(input logic [1:0] p,
		input logic [1:0] last, input logic big);
		lane = big ? last - p : p;
	endfunction

	function automatic logic [DW-1:0] out_part(input logic [DW-1:0] wd,
		input bmf_width_e w, input logic [1:0] li);
		case (w)
			BMF_W18: out_part = DW'(wd[`BMF_HALF*li[0] +: `BMF_HALF]);
			BMF_W9: out_part = DW'(wd[`BMF_BYTE*li +: `BMF_BYTE]);
			default: out_part = wd;
		endcase
	endfunction

	function automatic logic [OW-1:0] def_ofs(input logic [2:0] s);
		case (s)
			3'h0: def_ofs = OW'(`BMF_OFS_D0);
			3'h1: def_ofs = OW'(`BMF_OFS_D1);
			3'h2: def_ofs = OW'(`BMF_OFS_D2);
			3'h3: def_ofs = OW'(`BMF_OFS_D3);
			3'h4: def_ofs = OW'(`BMF_OFS_D4);
			3'h5: def_ofs = OW'(`BMF_OFS_D5);
			3'h6: def_ofs = OW'(`BMF_OFS_D6);
			default: def_ofs = OW'(`BMF_OFS_D7);
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	logic master_reset_n, partial_reset_n, clr, ld, wr_req, rd_req, ser_ld, par_ld, rt;
	assign master_reset_n = !master_reset_n_i;
	assign partial_reset_n = !partial_reset_n_i;
	assign clr = master_reset_n || partial_reset_n;
	assign ld = !offset_load_n_i;
	assign wr_req = !write_enable_n_i && !ld && !clr;
	assign rd_req = !read_enable_n_i && !ld && !clr;
	assign ser_ld = !serial_load_enable_n_i && ld;
	assign par_ld = !write_enable_n_i && ld && !ser_ld;
	assign rt = !retransmit_request_n_i && !clr;

	// ----------------------------------------
	// Straps, held through master reset only
	// ----------------------------------------
	logic fall_through_mode_q, fall_through_mode_d, pfm_q, pfm_d, rm_q, rm_d, be_q, be_d, ip_q, ip_d;
	bmf_width_e win_q, win_d, wout_q, wout_d;
	// Last level before release wins; partial reset leaves these alone
	always_comb begin
		{fall_through_mode_d, pfm_d, rm_d, be_d, ip_d} = {fall_through_mode_q, pfm_q, rm_q, be_q, ip_q};
		win_d = win_q;
		wout_d = wout_q;
		if (master_reset_n) begin
			fall_through_mode_d = fall_through_serial_in_i;
			pfm_d = flag_timing_select_i;
			rm_d = retransmit_latency_select_i;
			be_d = byte_order_select_i;
			ip_d = parity_layout_select_i;
			win_d = BMF_W36;
			wout_d = BMF_W36;
			if (width_match_enable_i && input_width_select_i) begin
				win_d = output_width_select_i ? BMF_W9 : BMF_W18;
			end
			if (width_match_enable_i && !input_width_select_i) begin
				wout_d = output_width_select_i ? BMF_W9 : BMF_W18;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			{fall_through_mode_q, pfm_q, rm_q, be_q, ip_q} <= 5'h00;
			win_q <= BMF_W36;
			wout_q <= BMF_W36;
		end else begin
			{fall_through_mode_q, pfm_q, rm_q, be_q, ip_q} <= {fall_through_mode_d, pfm_d, rm_d, be_d, ip_d};
			win_q <= win_d;
			wout_q <= wout_d;
		end
	end

	// ----------------------------------------
	// Offsets: defaults, serial, parallel, bus
	// ----------------------------------------
	logic [OW-1:0] ae_q, ae_d, af_q, af_d;
	logic wsel_q, wsel_d, rsel_q, rsel_d;
	logic [31:0] pval;
	logic [2*OW-1:0] shv;
	logic axi_wr, axi_ae, axi_af;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	// Parity positions dropped only while loading offsets, never from data
	assign pval = ip_q ? {write_data_in_i[34:27], write_data_in_i[25:18],
		write_data_in_i[16:9], write_data_in_i[7:0]}
		: write_data_in_i[31:0];
	assign shv = {ae_q[OW-2:0], af_q, fall_through_serial_in_i};
	assign axi_ae = axi_wr && awaddr_q == `BMF_REG_AEOFS;
	assign axi_af = axi_wr && awaddr_q == `BMF_REG_AFOFS;
	// Pins win over a bus write landing in the same cycle
	always_comb begin
		ae_d = ae_q;
		af_d = af_q;
		wsel_d = wsel_q;
		rsel_d = rsel_q;
		if (master_reset_n) begin
			ae_d = def_ofs({offset_load_n_i, offset_select_1_i,
				offset_select_0_i});
			af_d = ae_d;
			wsel_d = 1'b0;
			rsel_d = 1'b0;
		end else if (ser_ld) begin
			ae_d = shv[2*OW-1:OW];
			af_d = shv[OW-1:0];
		end else if (par_ld) begin
			wsel_d = !wsel_q;
			if (wsel_q) begin
				af_d = pval[OW-1:0];
			end else begin
				ae_d = pval[OW-1:0];
			end
		end else if (axi_ae) begin
			ae_d = OW'(merge(32'(ae_q), wdata_q, wstrb_q));
		end else if (axi_af) begin
			af_d = OW'(merge(32'(af_q), wdata_q, wstrb_q));
		end
		if (!master_reset_n && !read_enable_n_i && ld) begin
			rsel_d = !rsel_q;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ae_q <= OW'(`BMF_OFS_D0);
			af_q <= OW'(`BMF_OFS_D0);
			wsel_q <= 1'b0;
			rsel_q <= 1'b0;
		end else begin
			ae_q <= ae_d;
			af_q <= af_d;
			wsel_q <= wsel_d;
			rsel_q <= rsel_d;
		end
	end

	// ----------------------------------------
	// Storage and write side
	// ----------------------------------------
	logic [DW-1:0] mem_q [2**AW];
	logic [OW-1:0] wptr_q, wptr_d, rptr_q, rptr_d, cnt, cnt_d;
	logic [1:0] wpart_q, wpart_d, wli;
	logic [DW-1:0] asm_q, asm_d, wword;
	logic push, empty, full;
	assign cnt = wptr_q - rptr_q;
	assign empty = cnt == '0;
	assign full = cnt == FULL_CNT;
	assign wli = lane(wpart_q, last_part(win_q), !be_q);
	// Narrow writes gather in a staging word; the last part commits it
	always_comb begin
		wptr_d = wptr_q;
		wpart_d = wpart_q;
		asm_d = asm_q;
		push = 1'b0;
		wword = write_data_in_i;
		if (win_q == BMF_W18) begin
			wword = asm_q;
			wword[`BMF_HALF*wli[0] +: `BMF_HALF] =
				write_data_in_i[`BMF_HALF-1:0];
		end else if (win_q == BMF_W9) begin
			wword = asm_q;
			wword[`BMF_BYTE*wli +: `BMF_BYTE] =
				write_data_in_i[`BMF_BYTE-1:0];
		end
		if (clr) begin
			wptr_d = '0;
			wpart_d = '0;
			asm_d = '0;
		end else if (wr_req && !full) begin
			if (wpart_q == last_part(win_q)) begin
				push = 1'b1;
				wptr_d = wptr_q + 1'b1;
				wpart_d = '0;
			end else begin
				wpart_d = wpart_q + 2'd1;
				asm_d = wword;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wptr_q[AW-1:0]] <= wword;
		end
	end

	// ----------------------------------------
	// Read side
	// ----------------------------------------
	bmf_rd_st_e st_q, st_d;
	logic [1:0] fc_q, fc_d, rpart_q, rpart_d, bpart, rli;
	logic [OW-1:0] bptr;
	logic [DW-1:0] dout_q, dout_d;
	logic pop;
	assign rli = lane(bpart, last_part(wout_q), !be_q);
	// Retransmit beats a read in the same cycle
	always_comb begin
		st_d = st_q;
		fc_d = fc_q;
		dout_d = dout_q;
		bptr = rptr_q;
		bpart = rpart_q;
		pop = 1'b0;
		if (rt) begin
			bptr = '0;
			bpart = '0;
			st_d = BMF_RS_EMPTY;
			if (!rm_q && wptr_q != '0) begin
				pop = 1'b1;
				st_d = BMF_RS_READY;
			end
		end else if (!clr && !read_enable_n_i && ld) begin
			dout_d = DW'(rsel_q ? af_q : ae_q);
		end else if (!fall_through_mode_q) begin
			pop = rd_req && !empty;
		end else if (!clr) begin
			case (st_q)
				BMF_RS_EMPTY: begin
					if (!empty) begin
						st_d = BMF_RS_FALL;
						fc_d = `BMF_FALL_START;
					end
				end
				BMF_RS_FALL: begin
					if (fc_q == `BMF_FALL_CYC - 2'd1) begin
						pop = 1'b1;
						st_d = BMF_RS_READY;
					end else begin
						fc_d = fc_q + 2'd1;
					end
				end
				BMF_RS_READY: begin
					if (rd_req) begin
						pop = !empty;
						st_d = empty ? BMF_RS_EMPTY : BMF_RS_READY;
					end
				end
				default: st_d = BMF_RS_EMPTY;
			endcase
		end
		rptr_d = bptr;
		rpart_d = bpart;
		if (pop) begin
			dout_d = out_part(mem_q[bptr[AW-1:0]], wout_q, rli);
			if (bpart == last_part(wout_q)) begin
				rptr_d = bptr + 1'b1;
				rpart_d = '0;
			end else begin
				rpart_d = bpart + 2'd1;
			end
		end
		if (clr) begin
			rptr_d = '0;
			rpart_d = '0;
			st_d = BMF_RS_EMPTY;
			fc_d = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wptr_q <= '0;
			wpart_q <= '0;
			asm_q <= '0;
			rptr_q <= '0;
			rpart_q <= '0;
			st_q <= BMF_RS_EMPTY;
			fc_q <= '0;
			dout_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			wpart_q <= wpart_d;
			asm_q <= asm_d;
			rptr_q <= rptr_d;
			rpart_q <= rpart_d;
			st_q <= st_d;
			fc_q <= fc_d;
			dout_q <= dout_d;
		end
	end

	// ----------------------------------------
	// Flags and idle indication
	// ----------------------------------------
	logic ef_q, ef_d, ff_q, ff_d, hf_q, hf_d, ae_n_q, ae_n_d, af_n_q, af_n_d;
	logic pd_q, pd_d;
	logic [OW-1:0] fcnt;
	assign cnt_d = wptr_d - rptr_d;
	// Sync timing lags the almost flags one edge behind the count; writes and reads both move each flag
	assign fcnt = pfm_q ? cnt : cnt_d;
	always_comb begin
		ef_d = fall_through_mode_q ? st_d != BMF_RS_READY : cnt_d != '0;
		ff_d = cnt_d != FULL_CNT;
		hf_d = !(cnt_d > HALF_CNT);
		ae_n_d = !(fcnt <= ae_q);
		af_n_d = !(fcnt >= FULL_CNT - af_q);
		pd_d = write_enable_n_i && read_enable_n_i && !ld && !clr &&
			serial_load_enable_n_i && retransmit_request_n_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			{ef_q, ff_q, hf_q, ae_n_q, af_n_q, pd_q} <= 6'h1a;
		end else begin
			{ef_q, ff_q, hf_q, ae_n_q, af_n_q, pd_q} <=
				{ef_d, ff_d, hf_d, ae_n_d, af_n_d, pd_d};
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bv_q, bv_d, awr_q, awr_d;
	logic wr_q, wr_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [7:0] awaddr_d;
	logic [31:0] wdata_d, rd_q, rd_d;
	logic [3:0] wstrb_d;
	assign axi_wr = aw_ok_q && w_ok_q && !bv_q;
	// Readback of live state; unmapped read offsets answer with an error, writes only above 0x0f
	always_comb begin
		aw_ok_d = aw_ok_q || (s_axi_awvalid && awr_q);
		w_ok_d = w_ok_q || (s_axi_wvalid && wr_q);
		awaddr_d = (s_axi_awvalid && awr_q) ? s_axi_awaddr : awaddr_q;
		wdata_d = (s_axi_wvalid && wr_q) ? s_axi_wdata : wdata_q;
		wstrb_d = (s_axi_wvalid && wr_q) ? s_axi_wstrb : wstrb_q;
		bv_d = bv_q && !s_axi_bready;
		br_d = br_q;
		if (axi_wr) begin
			aw_ok_d = 1'b0;
			w_ok_d = 1'b0;
			bv_d = 1'b1;
			br_d = awaddr_q[7:4] == 4'h0 ? `BMF_RESP_OK : `BMF_RESP_ERR;
		end
		awr_d = !aw_ok_d && !bv_d;
		wr_d = !w_ok_d && !bv_d;
		rv_d = rv_q && !s_axi_rready;
		rd_d = rd_q;
		rr_d = rr_q;
		if (arr_q && s_axi_arvalid) begin
			rv_d = 1'b1;
			rr_d = `BMF_RESP_OK;
			rd_d = '0;
			case (s_axi_araddr)
				`BMF_REG_STAT: begin
					rd_d[`BMF_STAT_CNT_LSB +: OW] = cnt;
					rd_d[`BMF_STAT_FLG_LSB +: `BMF_STAT_FLG_W] =
						{pd_q, af_n_q, ae_n_q, hf_q, ff_q, ef_q};
				end
				`BMF_REG_AEOFS: rd_d = 32'(ae_q);
				`BMF_REG_AFOFS: rd_d = 32'(af_q);
				`BMF_REG_CFG: rd_d = 32'({wout_q, win_q, ip_q, be_q, rm_q,
					pfm_q, fall_through_mode_q});
				default: rr_d = `BMF_RESP_ERR;
			endcase
		end
		arr_d = !rv_d;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			{aw_ok_q, w_ok_q, bv_q, rv_q} <= 4'h0;
			{awr_q, wr_q, arr_q} <= 3'h0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			br_q <= `BMF_RESP_OK;
			rr_q <= `BMF_RESP_OK;
			rd_q <= '0;
		end else begin
			{aw_ok_q, w_ok_q, bv_q, rv_q} <= {aw_ok_d, w_ok_d, bv_d, rv_d};
			{awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			br_q <= br_d;
			rr_q <= rr_d;
			rd_q <= rd_d;
		end
	end

	// Every output straight from a flop
	assign read_data_out_o = dout_q;
	assign {empty_flag_n_o, full_flag_n_o, half_full_flag_n_o} = {ef_q, ff_q, hf_q};
	assign {almost_empty_flag_n_o, almost_full_flag_n_o} = {ae_n_q, af_n_q};
	assign power_down_o = pd_q;
	assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awr_q, wr_q, arr_q};
	assign {s_axi_bvalid, s_axi_bresp} = {bv_q, br_q};
	assign {s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {rv_q, rr_q, rd_q};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic quiet;
	logic [DW-1:0] zl_word;
	assign quiet = !clr && retransmit_request_n_i && offset_load_n_i;
	assign zl_word = out_part(mem_q[0], wout_q,
		lane('0, last_part(wout_q), !be_q));
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_fall;
		(fall_through_mode_q && st_q == BMF_RS_FALL && fc_q == `BMF_FALL_START && quiet)
			##1 quiet |=> !empty_flag_n_o;
	endproperty
	a_fall: assert property (p_fall) else $error("no fall-through");

	property p_full;
		full && wr_req |=> wptr_q == $past(wptr_q);
	endproperty
	a_full: assert property (p_full) else $error("write when full");

	property p_empty;
		!fall_through_mode_q && empty && rd_req && quiet |=> rptr_q == $past(rptr_q);
	endproperty
	a_empty: assert property (p_empty) else $error("read when empty");

	property p_rt;
		rt && rm_q |=> rptr_q == '0 && rpart_q == '0;
	endproperty
	a_rt: assert property (p_rt) else $error("retransmit missed");

	property p_zl;
		rt && !rm_q && wptr_q != '0 |=> read_data_out_o == $past(zl_word);
	endproperty
	a_zl: assert property (p_zl) else $error("zero latency word");

	property p_prs;
		partial_reset_n && !master_reset_n |=> wptr_q == '0 && rptr_q == '0 && ae_q == $past(ae_q)
			&& fall_through_mode_q == $past(fall_through_mode_q);
	endproperty
	a_prs: assert property (p_prs) else $error("partial reset");

	property p_mrs;
		master_reset_n |=> wptr_q == '0 && fall_through_mode_q == $past(fall_through_serial_in_i);
	endproperty
	a_mrs: assert property (p_mrs) else $error("master reset");

	property p_ef;
		!fall_through_mode_q && !$past(fall_through_mode_q) |-> empty_flag_n_o == ($past(cnt_d) != '0);
	endproperty
	a_ef: assert property (p_ef) else $error("empty flag");

	property p_ser;
		ser_ld && !master_reset_n |=> af_q[0] == $past(fall_through_serial_in_i);
	endproperty
	a_ser: assert property (p_ser) else $error("serial load");

	property p_par;
		par_ld && !master_reset_n && !wsel_q |=> ae_q == OW'($past(pval));
	endproperty
	a_par: assert property (p_par) else $error("parallel load");

	property p_pd;
		!write_enable_n_i |=> !power_down_o;
	endproperty
	a_pd: assert property (p_pd) else $error("idle while active");
endmodule

// File: rtl/bmf_params.svh
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define BMF_ADDR_W 10
`define BMF_DATA_W 36
`define BMF_HALF 18
`define BMF_BYTE 9
`define BMF_LAST36 2'd0
`define BMF_LAST18 2'd1
`define BMF_LAST9 2'd3
// ----------------------------------------
// First word fall-through latency
// ----------------------------------------
`define BMF_FALL_CYC 2'd3
`define BMF_FALL_START 2'd1
// ----------------------------------------
// Default offset pairs, by {load, sel1, sel0}
// ----------------------------------------
`define BMF_OFS_D0 16'h0007
`define BMF_OFS_D1 16'h000f
`define BMF_OFS_D2 16'h001f
`define BMF_OFS_D3 16'h003f
`define BMF_OFS_D4 16'h007f
`define BMF_OFS_D5 16'h00ff
`define BMF_OFS_D6 16'h01ff
`define BMF_OFS_D7 16'h03ff
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define BMF_REG_STAT 8'h00
`define BMF_REG_AEOFS 8'h04
`define BMF_REG_AFOFS 8'h08
`define BMF_REG_CFG 8'h0c
`define BMF_STAT_CNT_LSB 0
`define BMF_STAT_FLG_LSB 16
`define BMF_STAT_FLG_W 6
`define BMF_RESP_OK 2'b00
`define BMF_RESP_ERR 2'b10
`endif

// File: rtl/bmf_pkg.sv
package bmf_pkg;
	// Read side fall-through states
	typedef enum logic [1:0] {
		BMF_RS_EMPTY = 2'b00,
		BMF_RS_FALL = 2'b01,
		BMF_RS_READY = 2'b10
	} bmf_rd_st_e;
	// Port widths
	typedef enum logic [1:0] {
		BMF_W36 = 2'b00,
		BMF_W18 = 2'b01,
		BMF_W9 = 2'b10
	} bmf_width_e;
endpackage

// File: verif/bmf_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Writer and reader logic beside the buffer
// ----------------------------------------
module bmf_peer (
	input wire logic wr_go_i,
	input wire logic [35:0] wr_word_i,
	input wire logic rd_go_i,
	output logic write_enable_n_o,
	output logic [35:0] write_data_in_o,
	output logic read_enable_n_o
);
	// One enable per word; the reader asks again for every later word
	assign write_enable_n_o = ~wr_go_i;
	assign read_enable_n_o = ~rd_go_i;
	// Idle data lines show the inverse, so a stale word cannot slip in
	assign write_data_in_o = wr_go_i ? wr_word_i : ~wr_word_i;
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
`include "bmf_params.svh"
module tb_top;
	logic core_clk_i, rst_n_i = 1'b0, mst_n = 1'b1, part_n = 1'b1;
	logic load_n = 1'b1, ser_n = 1'b1, fsi = 1'b0, sel0 = 1'b0;
	logic sel1 = 1'b0, ftime = 1'b0, rtx_n = 1'b1, rlat = 1'b0;
	logic order = 1'b0, par = 1'b0, wmatch = 1'b0, wide_in = 1'b0;
	logic wide_out = 1'b0, wr_go = 1'b0, rd_go = 1'b0, wen_n, ren_n;
	logic empty_n, full_n, half_n, aempty_n, afull_n, pdown;
	logic [35:0] wr_word = '0, din, dout;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	int mismatches = 0, comparisons = 0, i;
	// Serial offset pattern: almost-empty part first, then almost-full
	logic [21:0] spat = {11'h00c, 11'h0f0};
	// Table rows: word written, word expected back
	logic [71:0] rows [3] = '{{36'h8_0000_0001, 36'h8_0000_0001},
		{36'hf_ffff_ffff, 36'hf_ffff_ffff}, {36'h0, 36'h0}};
	// ----------------------------------------
	// Clock and instances
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	bmf_peer i_peer (.wr_go_i(wr_go), .wr_word_i(wr_word), .rd_go_i(rd_go),
		.write_enable_n_o(wen_n), .write_data_in_o(din),
		.read_enable_n_o(ren_n));
	bmf_fifo i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.master_reset_n_i(mst_n), .partial_reset_n_i(part_n),
		.write_enable_n_i(wen_n), .write_data_in_i(din),
		.read_enable_n_i(ren_n), .read_data_out_o(dout),
		.offset_load_n_i(load_n), .serial_load_enable_n_i(ser_n),
		.fall_through_serial_in_i(fsi), .offset_select_0_i(sel0),
		.offset_select_1_i(sel1), .flag_timing_select_i(ftime),
		.retransmit_request_n_i(rtx_n), .retransmit_latency_select_i(rlat),
		.byte_order_select_i(order), .parity_layout_select_i(par),
		.width_match_enable_i(wmatch), .input_width_select_i(wide_in),
		.output_width_select_i(wide_out), .empty_flag_n_o(empty_n),
		.full_flag_n_o(full_n), .half_full_flag_n_o(half_n),
		.almost_empty_flag_n_o(aempty_n), .almost_full_flag_n_o(afull_n),
		.power_down_o(pdown), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string n, input logic [35:0] e, input logic [35:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_sim;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// A wait that runs out ends the run
	task tmo(input int n);
		if (n >= 99) begin
			mismatches++;
			end_sim;
		end
	endtask
	// Outputs are read one edge after the request is taken: settled values
	task put(input logic [35:0] w);
		wr_go <= 1'b1;
		wr_word <= w;
		step(1);
	endtask
	task get;
		rd_go <= 1'b1;
		step(1);
	endtask
	task idle;
		wr_go <= 1'b0;
		rd_go <= 1'b0;
		step(1);
	endtask
	task master_reset_n;
		mst_n <= 1'b0;
		step(1);
		mst_n <= 1'b1;
		fsi <= 1'b0;
		load_n <= 1'b1;
		step(2);
	endtask
	task axr(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			step(1);
			if (arready) break;
		end
		tmo(n);
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			step(1);
			if (rvalid) break;
		end
		tmo(n);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		step(1);
	endtask
	// Address and data offered together, each dropped once taken
	task axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 99 && !(ad && wd); n++) begin
			step(1);
			ad = ad | awready;
			wd = wd | wready;
			awvalid <= ~ad;
			wvalid <= ~wd;
		end
		tmo(n);
		for (n = 0; n < 99 && !bvalid; n++) begin
			step(1);
		end
		tmo(n);
		rs = bresp;
		bready <= 1'b0;
		step(1);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		step(2);
		rst_n_i <= 1'b1;
		step(1);
		chk("empty", 0, empty_n);
		chk("full", 1, full_n);
		load_n <= 1'b0;
		sel0 <= 1'b1;
		sel1 <= 1'b1;
		master_reset_n;
		chk("idle", 1, pdown);
		axr(`BMF_REG_AEOFS);
		chk("ae offset", `BMF_OFS_D3, rd);
		axw(`BMF_REG_AEOFS, 32'h0000000a);
		chk("bresp", `BMF_RESP_OK, rs);
		axr(`BMF_REG_AEOFS);
		chk("ae offset", 36'h00a, rd);
		axr(8'h10);
		chk("rresp", `BMF_RESP_ERR, rs);
		for (i = 0; i < 3; i++) put(rows[i][71:36]);
		idle;
		chk("empty", 1, empty_n);
		chk("aempty", 0, aempty_n);
		chk("idle", 0, pdown);
		for (i = 0; i < 3; i++) begin
			get;
			idle;
			chk("dout", rows[i][35:0], dout);
		end
		chk("empty", 0, empty_n);
		get;
		idle;
		chk("dout", rows[2][35:0], dout);
		for (i = 0; i < 1024; i++) put(36'(i));
		put(36'h5a5);
		idle;
		chk("full", 0, full_n);
		chk("half", 0, half_n);
		chk("afull", 0, afull_n);
		chk("aempty", 1, aempty_n);
		get;
		idle;
		chk("dout", 36'h0, dout);
		axr(`BMF_REG_STAT);
		chk("count", 1023, rd[10:0]);
		part_n <= 1'b0;
		step(1);
		part_n <= 1'b1;
		step(2);
		chk("empty", 0, empty_n);
		chk("afull", 1, afull_n);
		axr(`BMF_REG_AEOFS);
		chk("ae offset", 36'h00a, rd);
		put(36'h1_1111_1111);
		put(36'h2_2222_2222);
		idle;
		get;
		idle;
		get;
		idle;
		rtx_n <= 1'b0;
		step(1);
		rtx_n <= 1'b1;
		step(1);
		chk("dout", 36'h1_1111_1111, dout);
		// Parallel load: top nibble ignored, bit 8 kept
		load_n <= 1'b0;
		put(36'hf_0000_0105);
		put(36'h0_0000_0033);
		idle;
		get;
		idle;
		chk("ae readback", 36'h105, dout);
		get;
		idle;
		chk("af readback", 36'h033, dout);
		ser_n <= 1'b0;
		for (i = 0; i < 22; i++) begin
			fsi <= spat[21 - i];
			step(1);
		end
		ser_n <= 1'b1;
		load_n <= 1'b1;
		axr(`BMF_REG_AFOFS);
		chk("af serial", 36'h0f0, rd);
		fsi <= 1'b1;
		master_reset_n;
		put(36'h3_0c0c_0c0c);
		idle;
		step(2);
		chk("ready", 1, empty_n);
		step(1);
		chk("ready", 0, empty_n);
		chk("dout", 36'h3_0c0c_0c0c, dout);
		// Both byte orders through a 36 in, 18 out port
		for (i = 0; i < 2; i++) begin
			wmatch <= 1'b1;
			ftime <= 1'b1;
			rlat <= 1'b1;
			order <= i[0];
			master_reset_n;
			put(36'h9_8765_4321);
			idle;
			get;
			idle;
			chk("dout", i ? 36'h14321 : 36'h261d9, dout);
			get;
			idle;
			chk("dout", i ? 36'h261d9 : 36'h14321, dout);
			// Normal latency: the first part comes back on the next read
			rtx_n <= 1'b0;
			step(1);
			rtx_n <= 1'b1;
			get;
			idle;
			chk("dout", i ? 36'h14321 : 36'h261d9, dout);
		end
		end_sim;
	end
endmodule
